// ### core/pafo_pkg.sv
`default_nettype none

package pafo_pkg;

   // port width and fixed pin roles
   localparam int PAFO_PINS      = 8;
   localparam int PAFO_AW        = 8;
   localparam int PIN_CMP_POS    = 1;
   localparam int PIN_CMP_NEG    = 2;
   localparam int PIN_TIMER_CLK  = 4;
   localparam int PIN_TIMER_CMPB = 5;

   // register byte offsets
   localparam logic [7:0] OFS_DIR    = 8'h00;
   localparam logic [7:0] OFS_OUT    = 8'h04;
   localparam logic [7:0] OFS_PULLUP = 8'h08;
   localparam logic [7:0] OFS_PIN    = 8'h0C;
   localparam logic [7:0] OFS_PCMSK  = 8'h10;
   localparam logic [7:0] OFS_CTRL   = 8'h14;
   localparam logic [7:0] OFS_ADIS   = 8'h18;
   localparam logic [7:0] OFS_STAT   = 8'h1C;

   // reset values and field positions
   localparam logic [7:0] RST_REG       = 8'h00;
   localparam logic       RST_GRP0      = 1'b0;
   localparam int         CTRL_GRP0_BIT = 0;
   localparam int         STAT_OE_LSB   = 0;
   localparam int         STAT_PU_LSB   = 8;
   localparam int         STAT_IE_LSB   = 16;

   // sleep controller mode codes
   localparam logic [1:0] SLP_IDLE       = 2'h0;
   localparam logic [1:0] SLP_ADC_NR     = 2'h1;
   localparam logic [1:0] SLP_POWER_DOWN = 2'h2;
   localparam logic [1:0] SLP_STANDBY    = 2'h3;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pafo_pkg

`default_nettype wire

// ### core/pafo_ovr_if.sv
`default_nettype none

// per-pin override requests from the alternate-function owners
interface pafo_ovr_if;
   logic [pafo_pkg::PAFO_PINS-1:0] pullup_override_en;
   logic [pafo_pkg::PAFO_PINS-1:0] pullup_override_val;
   logic [pafo_pkg::PAFO_PINS-1:0] direction_override_en;
   logic [pafo_pkg::PAFO_PINS-1:0] direction_override_val;
   logic [pafo_pkg::PAFO_PINS-1:0] port_value_override_en;
   logic [pafo_pkg::PAFO_PINS-1:0] port_value_override_val;
   logic [pafo_pkg::PAFO_PINS-1:0] port_toggle_override_en;
   logic [pafo_pkg::PAFO_PINS-1:0] input_enable_override_en;
   logic [pafo_pkg::PAFO_PINS-1:0] input_enable_override_val;

   modport drive (
      output pullup_override_en, pullup_override_val,
      output direction_override_en, direction_override_val,
      output port_value_override_en, port_value_override_val,
      output port_toggle_override_en,
      output input_enable_override_en, input_enable_override_val
   );

   modport take (
      input pullup_override_en, pullup_override_val,
      input direction_override_en, direction_override_val,
      input port_value_override_en, port_value_override_val,
      input port_toggle_override_en,
      input input_enable_override_en, input_enable_override_val
   );
endinterface : pafo_ovr_if

`default_nettype wire

// ### core/pafo_ovr_mux.sv
`default_nettype none

module pafo_ovr_mux
   import pafo_pkg::*;
(
   pafo_ovr_if.take                  ovr,
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [PAFO_PINS-1:0] pin_pullup_bit,
   input  wire logic [PAFO_PINS-1:0] pin_direction_bit,
   input  wire logic [PAFO_PINS-1:0] pin_output_latch,
   input  wire logic                 sleep_clamp,
   output logic      [PAFO_PINS-1:0] pad_pullup_en,
   output logic      [PAFO_PINS-1:0] pad_oe,
   output logic      [PAFO_PINS-1:0] pad_out,
   output logic      [PAFO_PINS-1:0] input_en
);

   // one override cell per pin; purely combinational so an owner's
   // request reaches the pad in the same cycle
   for (genvar i = 0; i < PAFO_PINS; i++)
   begin : g_pin
      // pull-up: override value wins while its enable is high
      assign pad_pullup_en[i] = ovr.pullup_override_en[i] ?
                                ovr.pullup_override_val[i] :
                                pin_pullup_bit[i];
      // output driver enable
      assign pad_oe[i] = ovr.direction_override_en[i] ?
                         ovr.direction_override_val[i] :
                         pin_direction_bit[i];
      // driven level; only meaningful while pad_oe is high
      assign pad_out[i] = ovr.port_value_override_en[i] ?
                          ovr.port_value_override_val[i] :
                          pin_output_latch[i];
      // digital input enable; the clamp applies only without override
      assign input_en[i] = ovr.input_enable_override_en[i] ?
                           ovr.input_enable_override_val[i] :
                           !sleep_clamp;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_pullup_select: assert property (
      ((pad_pullup_en ^ pin_pullup_bit) & ~ovr.pullup_override_en) == '0 &&
      ((pad_pullup_en ^ ovr.pullup_override_val) & ovr.pullup_override_en) == '0)
      else $error("pull-up select wrong");

   chk_driver_select: assert property (
      ((pad_oe ^ pin_direction_bit) & ~ovr.direction_override_en) == '0 &&
      ((pad_oe ^ ovr.direction_override_val) & ovr.direction_override_en) == '0)
      else $error("driver enable select wrong");

   chk_value_select: assert property (
      ((pad_out ^ pin_output_latch) & pad_oe & ~ovr.port_value_override_en) == '0 &&
      ((pad_out ^ ovr.port_value_override_val) & pad_oe
       & ovr.port_value_override_en) == '0)
      else $error("driven level select wrong");

   chk_input_select: assert property (
      ((input_en ^ ovr.input_enable_override_val)
       & ovr.input_enable_override_en) == '0 &&
      ((input_en ^ {PAFO_PINS{!sleep_clamp}}) & ~ovr.input_enable_override_en) == '0)
      else $error("input enable select wrong");

endmodule : pafo_ovr_mux

`default_nettype wire

// ### core/pafo_port_a.sv
`default_nettype none

module pafo_port_a
   import pafo_pkg::*;
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // register bus
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [PAFO_AW-1:0]   awaddr,
   input  wire logic [2:0]           awprot,
   input  wire logic                 wvalid,
   output logic                      wready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   output logic                      bvalid,
   input  wire logic                 bready,
   output logic      [1:0]           bresp,
   input  wire logic                 arvalid,
   output logic                      arready,
   input  wire logic [PAFO_AW-1:0]   araddr,
   input  wire logic [2:0]           arprot,
   output logic                      rvalid,
   input  wire logic                 rready,
   output logic      [31:0]          rdata,
   output logic      [1:0]           rresp,
   // pad side
   input  wire logic [PAFO_PINS-1:0] pad_in,
   output logic      [PAFO_PINS-1:0] pad_out,
   output logic      [PAFO_PINS-1:0] pad_oe,
   output logic      [PAFO_PINS-1:0] pad_pullup_en,
   // sleep controller
   input  wire logic                 sleep_active,
   input  wire logic [1:0]           sleep_mode,
   // timer
   input  wire logic                 timer_compare_b_en,
   input  wire logic                 timer_compare_b_out,
   output logic                      timer_ext_count_clock,
   // pin change, analog, comparator
   output logic      [PAFO_PINS-1:0] pin_change_source,
   output logic      [PAFO_PINS-1:0] pin_change_mask,
   output logic                      pin_change_group0_enable,
   output logic      [PAFO_PINS-1:0] analog_pad_link,
   output logic                      comparator_positive_in,
   output logic                      comparator_negative_in,
   output logic      [PAFO_PINS-1:0] alt_func_input_tap
);

   // register state
   logic [PAFO_PINS-1:0] dir_q;      // direction bits
   logic [PAFO_PINS-1:0] out_q;      // output latch
   logic [PAFO_PINS-1:0] pullup_q;   // pull-up bits
   logic [PAFO_PINS-1:0] pcmsk_q;    // pin-change mask
   logic [PAFO_PINS-1:0] adis_q;     // analog digital-input disable
   logic                 grp0_q;     // pin-change group 0 enable
   logic [PAFO_PINS-1:0] sync1_q;    // first synchroniser stage
   logic [PAFO_PINS-1:0] sync2_q;    // synchronised pin level
   // bus state
   logic                 aw_hold_q;  // write address captured
   logic                 w_hold_q;   // write data captured
   logic [PAFO_AW-1:0]   awaddr_q;
   logic [31:0]          wdata_q;
   logic [3:0]           wstrb_q;
   logic                 bvalid_q;
   logic [1:0]           bresp_q;
   logic                 rvalid_q;
   logic [31:0]          rdata_q;
   logic [1:0]           rresp_q;
   logic [31:0]          rd_d;       // read mux
   logic                 rd_hit;
   // derived
   logic                 do_wr;
   logic                 wr_hit;
   logic                 lane0;
   logic                 sleep_clamp;
   logic [PAFO_PINS-1:0] input_en;
   logic [PAFO_PINS-1:0] pc_active;

   pafo_ovr_if ovr ();

   // bus handshakes; address and data may come in either order
   assign awready = !aw_hold_q && !bvalid_q;
   assign wready  = !w_hold_q && !bvalid_q;
   assign arready = !rvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;
   assign do_wr   = aw_hold_q && w_hold_q && !bvalid_q;
   // registers are 8 bits wide, so only byte lane 0 stores
   assign lane0   = wstrb_q[0];

   // write address capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_q <= 1'b0;
         awaddr_q  <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_hold_q <= 1'b1;
         awaddr_q  <= awaddr;
      end
      else if (do_wr)
         aw_hold_q <= 1'b0;
   end

   // write data capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_hold_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end
      else if (wvalid && wready)
      begin
         w_hold_q <= 1'b1;
         wdata_q  <= wdata;
         wstrb_q  <= wstrb;
      end
      else if (do_wr)
         w_hold_q <= 1'b0;
   end

   // unmapped offsets answer with a slave error and store nothing
   always_comb
   begin
      unique case (awaddr_q)
         OFS_DIR, OFS_OUT, OFS_PULLUP, OFS_PIN,
         OFS_PCMSK, OFS_CTRL, OFS_ADIS, OFS_STAT: wr_hit = 1'b1;
         default:                                 wr_hit = 1'b0;
      endcase
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (do_wr)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid_q <= 1'b0;
   end

   // one strobe per register loads all pins of the port at once
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dir_q    <= RST_REG;
         pullup_q <= RST_REG;
         pcmsk_q  <= RST_REG;
         adis_q   <= RST_REG;
         grp0_q   <= RST_GRP0;
      end
      else if (do_wr && lane0)
      begin
         if (awaddr_q == OFS_DIR)    dir_q    <= wdata_q[PAFO_PINS-1:0];
         if (awaddr_q == OFS_PULLUP) pullup_q <= wdata_q[PAFO_PINS-1:0];
         if (awaddr_q == OFS_PCMSK)  pcmsk_q  <= wdata_q[PAFO_PINS-1:0];
         if (awaddr_q == OFS_ADIS)   adis_q   <= wdata_q[PAFO_PINS-1:0];
         if (awaddr_q == OFS_CTRL)   grp0_q   <= wdata_q[CTRL_GRP0_BIT];
      end
   end

   // output latch: a write of ones to the pin register toggles, and a
   // toggle override inverts the bit on top of any bus write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         out_q <= RST_REG;
      else
         out_q <= ((do_wr && lane0 && awaddr_q == OFS_OUT) ?
                   wdata_q[PAFO_PINS-1:0] : out_q)
                  ^ ((do_wr && lane0 && awaddr_q == OFS_PIN) ?
                     wdata_q[PAFO_PINS-1:0] : RST_REG)
                  ^ ovr.port_toggle_override_en;
   end

   // pin level synchroniser; the clamp acts ahead of it, as at the
   // input buffer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= pad_in & input_en;
         sync2_q <= sync1_q;
      end
   end

   // read mux; status shows the live pad controls
   always_comb
   begin
      rd_d   = '0;
      rd_hit = 1'b1;
      unique case (araddr)
         OFS_DIR:    rd_d[PAFO_PINS-1:0] = dir_q;
         OFS_OUT:    rd_d[PAFO_PINS-1:0] = out_q;
         OFS_PULLUP: rd_d[PAFO_PINS-1:0] = pullup_q;
         OFS_PIN:    rd_d[PAFO_PINS-1:0] = sync2_q;
         OFS_PCMSK:  rd_d[PAFO_PINS-1:0] = pcmsk_q;
         OFS_CTRL:   rd_d[CTRL_GRP0_BIT] = grp0_q;
         OFS_ADIS:   rd_d[PAFO_PINS-1:0] = adis_q;
         OFS_STAT:
         begin
            rd_d[STAT_OE_LSB +: PAFO_PINS] = pad_oe;
            rd_d[STAT_PU_LSB +: PAFO_PINS] = pad_pullup_en;
            rd_d[STAT_IE_LSB +: PAFO_PINS] = input_en;
         end
         default:    rd_hit = 1'b0;
      endcase
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= '0;
         rresp_q  <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_d;
         rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
         rvalid_q <= 1'b0;
   end

   // clamp only in the deep sleep modes; idle keeps inputs alive
   assign sleep_clamp = sleep_active &&
      (sleep_mode == SLP_POWER_DOWN || sleep_mode == SLP_STANDBY);

   // owners without a request on this port stay quiet
   assign ovr.pullup_override_en      = '0;
   assign ovr.pullup_override_val     = '0;
   assign ovr.direction_override_en   = '0;
   assign ovr.direction_override_val  = '0;
   assign ovr.port_toggle_override_en = '0;
   // compare B takes the value but not the direction of its pin
   assign ovr.port_value_override_en  =
      PAFO_PINS'(timer_compare_b_en) << PIN_TIMER_CMPB;
   assign ovr.port_value_override_val =
      PAFO_PINS'(timer_compare_b_out) << PIN_TIMER_CMPB;
   // pin-change wake keeps the input alive, even on an analog-disabled pin; analog disable alone kills it
   assign pc_active = pcmsk_q & {PAFO_PINS{grp0_q}};
   assign ovr.input_enable_override_en  = pc_active | adis_q;
   assign ovr.input_enable_override_val = pc_active;

   pafo_ovr_mux u_mux (
      .ovr               (ovr),
      .aclk              (aclk),
      .aresetn           (aresetn),
      .pin_pullup_bit    (pullup_q),
      .pin_direction_bit (dir_q),
      .pin_output_latch  (out_q),
      .sleep_clamp       (sleep_clamp),
      .pad_pullup_en     (pad_pullup_en),
      .pad_oe            (pad_oe),
      .pad_out           (pad_out),
      .input_en          (input_en)
   );

   // raw tap: no synchroniser, receivers that are not clocked by it
   // must add their own
   assign alt_func_input_tap = pad_in & input_en;
   // analog path bypasses every gate and carries the pad level straight out
   assign analog_pad_link    = pad_in;
   assign comparator_positive_in   = pad_in[PIN_CMP_POS];
   assign comparator_negative_in   = pad_in[PIN_CMP_NEG];
   assign timer_ext_count_clock    = alt_func_input_tap[PIN_TIMER_CLK];
   assign pin_change_source        = alt_func_input_tap;
   assign pin_change_mask          = pcmsk_q;
   assign pin_change_group0_enable = grp0_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_tap_before_sync: assert property (
      alt_func_input_tap == (pad_in & input_en))
      else $error("alternate input tap not gated pad");

   chk_analog_direct: assert property (
      analog_pad_link == pad_in && comparator_positive_in == pad_in[1]
      && comparator_negative_in == pad_in[2])
      else $error("analog link not straight to pad");

   chk_timer_clock_pin: assert property (
      timer_ext_count_clock == alt_func_input_tap[4]
      && pin_change_source == alt_func_input_tap)
      else $error("timer clock or pin-change source wrong");

   chk_compare_b_pin: assert property (
      (timer_compare_b_en && dir_q[5]) |->
         (pad_oe[5] && pad_out[5] == timer_compare_b_out))
      else $error("compare B not on pin 5");

   chk_compare_b_dir: assert property (
      !dir_q[5] |-> !pad_oe[5])
      else $error("pin 5 driven without direction bit");

   chk_wake_input_on: assert property (
      (pc_active & ~input_en) == '0 && (adis_q & ~pc_active & input_en) == '0)
      else $error("input override from mask wrong");

   chk_deep_sleep_clamp: assert property (
      (sleep_active && sleep_mode == SLP_STANDBY) |->
         (input_en & ~(pc_active | adis_q)) == '0)
      else $error("standby clamp missing");

   chk_dir_strobe: assert property (
      (do_wr && lane0 && awaddr_q == OFS_DIR) |=> dir_q == $past(wdata_q[7:0]))
      else $error("direction write lost");

   chk_pin_toggle: assert property (
      (do_wr && lane0 && awaddr_q == OFS_PIN) |=>
         out_q == ($past(out_q) ^ $past(wdata_q[7:0])))
      else $error("pin write did not toggle latch");

   chk_write_answer: assert property (
      (awvalid && awready && wvalid && wready) |=> ##1 bvalid)
      else $error("write response late");

   chk_read_answer: assert property (
      (arvalid && arready) |=> rvalid)
      else $error("read answer late");

   cov_write_done:  cover property (bvalid && bready);
   cov_read_done:   cover property (rvalid && rready);
   cov_compare_out: cover property (timer_compare_b_en && pad_oe[5]);
   cov_sleep_clamp: cover property (sleep_clamp && input_en == '0);

endmodule : pafo_port_a

`default_nettype wire

// ### testbench/pafo_pad_model.sv
`default_nettype none

module pafo_pad_model
   import pafo_pkg::*;
(
   input  wire logic [PAFO_PINS-1:0] pad_out,
   input  wire logic [PAFO_PINS-1:0] pad_oe,
   input  wire logic [PAFO_PINS-1:0] pad_pullup_en,
   input  wire logic [PAFO_PINS-1:0] ext_level,
   output logic      [PAFO_PINS-1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // a driven pin shows its own level, a pulled one reads high, the rest follow the board
   always_comb
   begin
      pad_in = (pad_oe & pad_out) | (~pad_oe & pad_pullup_en)
               | (~pad_oe & ~pad_pullup_en & ext_level);
   end
endmodule : pafo_pad_model

`default_nettype wire

// ### testbench/port_alt_function_override_tb.sv
`default_nettype none

module port_alt_function_override_tb
   import pafo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0]  strb = 4'hF;
   logic        slp = 1'b0, tmr_en = 1'b0, tmr_v = 1'b0;
   logic [1:0]  mode = 2'h0;
   wire logic   awready, wready, bvalid, arready, rvalid, grp0, cpos, cneg, tclk;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [7:0]  pad_in, pad_out, pad_oe, pad_pu, tap, pcs, pcm, apl;
   int          n_fail = 0;
   int          num_checks = 0;
   // reference state of the port, kept as plain integers
   int          dir, outl, pu, msk, grp, adis, ie, pin, po, tg, it, a;
   logic [31:0] rd;

   always #10 aclk = ~aclk;

   pafo_port_a u_dut (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(strb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .pad_pullup_en(pad_pu), .sleep_active(slp), .sleep_mode(mode),
      .timer_compare_b_en(tmr_en), .timer_compare_b_out(tmr_v), .timer_ext_count_clock(tclk),
      .pin_change_source(pcs), .pin_change_mask(pcm), .pin_change_group0_enable(grp0),
      .analog_pad_link(apl), .comparator_positive_in(cpos), .comparator_negative_in(cneg),
      .alt_func_input_tap(tap)
   );

   pafo_pad_model u_pad (
      .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup_en(pad_pu), .ext_level(ext), .pad_in(pad_in)
   );

   // verdict and end of run, shared by the main sequence and every timeout
   task automatic conclude;
      if (n_fail == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one write; each channel is released at the edge that takes it
   task automatic wr(input logic [7:0] ad, input int d, input logic [1:0] er);
      int n;
      @(posedge aclk);
      awaddr  <= ad;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      bready <= 1'b0;
      if (n == 50)
      begin
         n_fail++;
         conclude();
      end
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr

   task automatic rdr(input logic [7:0] ad, input logic [1:0] er);
      int n;
      @(posedge aclk);
      araddr  <= ad;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arready === 1'b1)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      rready <= 1'b0;
      rd = rdata;
      if (n == 50)
      begin
         n_fail++;
         conclude();
      end
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rdr

   // reference pads: override enable is mask and group enable, or analog disable
   task automatic model_pads;
      tg  = grp ? msk : 0;
      ie  = (tg | (~(tg | adis) & ((slp && mode >= 2) ? 0 : 255))) & 255;
      po  = tmr_en ? ((outl & 8'hDF) | {tmr_v, 5'h00}) : outl;
      pin = ((dir & po) | (~dir & pu) | (~dir & ~pu & ext)) & 255;
   endtask : model_pads

   function automatic logic [31:0] exp_reg(input int ad);
      case (ad)
         0: return dir;
         4: return outl;
         8: return pu;
         12: return pin & ie;
         16: return msk;
         20: return grp;
         24: return adis;
         default: return {8'h00, ie[7:0], pu[7:0], dir[7:0]};
      endcase
   endfunction : exp_reg

   // pads, taps and every register against the reference
   task automatic check_all;
      logic [31:0] g, e;
      model_pads();
      #1;
      g = {16'h0000, pad_oe, pad_pu};
      e = {16'h0000, dir[7:0], pu[7:0]};
      chk(g, e);
      g = {16'h0000, pad_out, tap};
      e = {16'h0000, po[7:0], pin[7:0] & ie[7:0]};
      chk(g, e);
      g = {apl, pcs, pcm, 4'h0, grp0, cpos, cneg, tclk};
      e = {pin[7:0], pin[7:0] & ie[7:0], msk[7:0], 4'h0, grp[0], pin[1], pin[2], pin[4] & ie[4]};
      chk(g, e);
      for (a = 0; a < 32; a += 4)
      begin
         rdr(a[7:0], RESP_OKAY);
         chk(rd, exp_reg(a));
      end
      rdr(8'h24, RESP_SLVERR);
      chk(rd, 32'h00000000);
   endtask : check_all

   initial
   begin
      void'($urandom(22));
      {dir, outl, pu, msk, grp, adis} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      check_all();
      for (it = 0; it < 12; it++)
      begin
         // every sleep code, clamp on and off; timer takes pin 5 as it likes
         dir  = $urandom & 255;
         outl = $urandom & 255;
         pu   = $urandom & 255;
         msk  = $urandom & 255;
         adis = $urandom & 255;
         grp = $urandom & 1;
         // comparator pins left as plain inputs without pull-up on odd passes
         if (it[0])
         begin
            dir = dir & 8'hF9;
            pu  = pu & 8'hF9;
         end
         @(posedge aclk);
         ext    <= 8'($urandom);
         mode   <= it[1:0];
         slp    <= it[2];
         tmr_en <= 1'($urandom);
         tmr_v  <= 1'($urandom);
         wr(OFS_DIR, dir, RESP_OKAY);
         wr(OFS_OUT, outl, RESP_OKAY);
         wr(OFS_PULLUP, pu, RESP_OKAY);
         wr(OFS_PCMSK, msk, RESP_OKAY);
         wr(OFS_CTRL, grp, RESP_OKAY);
         wr(OFS_ADIS, adis, RESP_OKAY);
         tg = $urandom & 255;
         wr(OFS_PIN, tg, RESP_OKAY);
         outl ^= tg;
         wr(OFS_STAT, 255, RESP_OKAY);
         // without byte lane 0 the write is answered but stores nothing
         strb <= 4'hE;
         wr(OFS_DIR, ~dir & 255, RESP_OKAY);
         strb <= 4'hF;
         wr(8'h20, 255, RESP_SLVERR);
         check_all();
      end
      conclude();
   end
endmodule : port_alt_function_override_tb

`default_nettype wire
